// [src/crf_pkg.sv]
// Package for the core register file: register selectors, status word layout and reset values.
// Assumes a 32-bit datapath and one core clock.
package crf_pkg;

  // ==========================================================
  // Widths and register indices
  localparam int          CRF_XLEN        = 32;
  localparam int          CRF_NGPR        = 16;
  localparam logic [3:0]  CRF_INDEX_GPR   = 4'h0;
  localparam logic [3:0]  CRF_STACK_GPR   = 4'hf;

  // ==========================================================
  // Software port offsets
  localparam logic [7:0]  CRF_GPR_BASE    = 8'h00;
  localparam logic [7:0]  CRF_STATUS_OFF  = 8'h40;
  localparam logic [7:0]  CRF_PBASE_OFF   = 8'h44;
  localparam logic [7:0]  CRF_VBASE_OFF   = 8'h48;
  localparam logic [7:0]  CRF_PC_OFF      = 8'h4c;

  // ==========================================================
  // Status word fields
  localparam int          CRF_SW_MFLAG    = 9;
  localparam int          CRF_SW_QFLAG    = 8;
  localparam int          CRF_SW_IMASK_HI = 7;
  localparam int          CRF_SW_IMASK_LO = 4;
  localparam int          CRF_SW_SAT      = 1;
  localparam logic [31:0] CRF_SW_WMASK    = 32'h0000_03f2;
  localparam logic [31:0] CRF_SW_RESET    = 32'h0000_00f0;
  localparam logic [31:0] CRF_ZERO        = 32'h0000_0000;
  localparam logic [31:0] CRF_STEP4       = 32'h0000_0004;

  // ==========================================================
  // Effective address modes
  typedef enum logic [2:0] {
    CRF_EA_REG, CRF_EA_INDEXED, CRF_EA_PBASE, CRF_EA_PCREL, CRF_EA_VECTOR
  } crf_eamode_t;

  // Datapath status word update.
  typedef struct packed {
    logic       we;
    logic       mFlag;
    logic       qFlag;
    logic       satFlag;
    logic [3:0] imask;
  } crf_swupd_t;

  // Exception stack request.
  typedef struct packed {
    logic push;
    logic pop;
  } crf_stkreq_t;

endpackage

// [src/crf_regfile.sv]
// Core general and control register file with a software register port.
// Assumes the execute datapath on mclk and a software master that never issues read and write together.
//
// Operation
// - Sixteen general registers of 32 bits, numbered zero to fifteen.
// - Every general register feeds operands and effective address calculation.
// - Register zero is the index register and the fixed-operand register.
// - Register fifteen is stack pointer for exception push and pop.
// - Three 32-bit control registers: status, peripheral base, vector base.
// - Peripheral-base mode adds operand offset to peripheral base register.
// - Vector addresses are formed relative to the vector base register.
// - Status bits 31:10, 3 and 2 reset to zero, read zero.
// - Status bits 9 and 8 are the divide-step flags.
// - Status bit 1 is the multiply-accumulate flag.
// - Wide immediates are fetched as literals at a PC-relative displacement.
`timescale 1ns/10ps
module crf_regfile
  import crf_pkg::*;
#(
  parameter int XLEN = CRF_XLEN,
  parameter int NGPR = CRF_NGPR
) (
  // Clock and reset.
  input  wire  logic              mclk,
  input  wire  logic              rst,
  // Datapath register access.
  input  wire  logic [3:0]        rdSelA,
  input  wire  logic [3:0]        rdSelB,
  input  wire  logic              gprWe,
  input  wire  logic [3:0]        gprWrSel,
  input  wire  logic [XLEN-1:0]   gprWrData,
  input  wire  logic              pbaseWe,
  input  wire  logic              vbaseWe,
  input  wire  logic [XLEN-1:0]   ctrlWrData,
  input  wire  crf_swupd_t        swUpd,
  input  wire  logic              pcWe,
  input  wire  logic [XLEN-1:0]   pcWrData,
  // Address calculation request.
  input  wire  crf_eamode_t       eaMode,
  input  wire  logic [XLEN-1:0]   eaDisp,
  // Exception stack request.
  input  wire  crf_stkreq_t       stkReq,
  // Datapath results.
  output logic [XLEN-1:0]         opA,
  output logic [XLEN-1:0]         opB,
  output logic [XLEN-1:0]         indexVal,
  output logic [XLEN-1:0]         effAddr,
  output logic [XLEN-1:0]         statusWord,
  output logic [XLEN-1:0]         stackPointer,
  // Software register port.
  input  wire  logic [7:0]        swAddr,
  input  wire  logic [XLEN-1:0]   swWrData,
  input  wire  logic              swWrite,
  input  wire  logic              swRead,
  output logic [XLEN-1:0]         swRdData
);

  // ==========================================================
  // State
  logic [XLEN-1:0] gprFile_ff [NGPR];
  logic [XLEN-1:0] pbase_ff;
  logic [XLEN-1:0] vbase_ff;
  logic [XLEN-1:0] pc_ff;
  logic            mFlag_ff;
  logic            qFlag_ff;
  logic            satFlag_ff;
  logic [3:0]      imask_ff;
  logic [XLEN-1:0] opA_ff;
  logic [XLEN-1:0] opB_ff;
  logic [XLEN-1:0] indexVal_ff;
  logic [XLEN-1:0] effAddr_ff;
  logic [XLEN-1:0] swRdData_ff;
  logic [XLEN-1:0] nxt_effAddr;
  logic [XLEN-1:0] nxt_swRdData;
  logic [XLEN-1:0] swView;
  logic            swGprHit;
  logic [3:0]      swGprSel;

  // Software decode: general registers sit at one word each from the base.
  assign swGprHit = (swAddr[7:6] == CRF_GPR_BASE[7:6]) && (swAddr[1:0] == 2'b00);
  assign swGprSel = swAddr[5:2];

  // Assembled status word; reserved bits are hard zeros so they always read zero.
  always_comb begin
    swView = CRF_ZERO;
    swView[CRF_SW_MFLAG] = mFlag_ff;
    swView[CRF_SW_QFLAG] = qFlag_ff;
    swView[CRF_SW_IMASK_HI:CRF_SW_IMASK_LO] = imask_ff;
    swView[CRF_SW_SAT] = satFlag_ff;
  end

  // ==========================================================
  // General registers
  // Priority per register: datapath write, then stack adjust on register fifteen, then software.
  // The array is not reset, so a flop-based memory stays cheap; software must initialise it.
  generate
    for (genvar g = 0; g < NGPR; g++) begin : gGpr
      always_ff @(posedge mclk) begin
        if (gprWe && (gprWrSel == 4'(g))) begin
          gprFile_ff[g] <= gprWrData;
        end else if ((4'(g) == CRF_STACK_GPR) && stkReq.push) begin
          gprFile_ff[g] <= gprFile_ff[g] - CRF_STEP4;
        end else if ((4'(g) == CRF_STACK_GPR) && stkReq.pop) begin
          gprFile_ff[g] <= gprFile_ff[g] + CRF_STEP4;
        end else if (swWrite && swGprHit && (swGprSel == 4'(g))) begin
          gprFile_ff[g] <= swWrData;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Control registers
  // Peripheral and vector base registers, written by datapath or software.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pbase_ff <= CRF_ZERO;
      vbase_ff <= CRF_ZERO;
    end else begin
      if (pbaseWe) begin
        pbase_ff <= ctrlWrData;
      end else if (swWrite && (swAddr == CRF_PBASE_OFF)) begin
        pbase_ff <= swWrData;
      end
      if (vbaseWe) begin
        vbase_ff <= ctrlWrData;
      end else if (swWrite && (swAddr == CRF_VBASE_OFF)) begin
        vbase_ff <= swWrData;
      end
    end
  end

  // Program counter, used for literal addressing.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_ff <= CRF_ZERO;
    end else if (pcWe) begin
      pc_ff <= pcWrData;
    end else if (swWrite && (swAddr == CRF_PC_OFF)) begin
      pc_ff <= swWrData;
    end
  end

  // Interrupt mask resets to all ones so nothing maskable gets through early.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      imask_ff <= CRF_SW_RESET[CRF_SW_IMASK_HI:CRF_SW_IMASK_LO];
    end else if (swUpd.we) begin
      imask_ff <= swUpd.imask;
    end else if (swWrite && (swAddr == CRF_STATUS_OFF)) begin
      imask_ff <= swWrData[CRF_SW_IMASK_HI:CRF_SW_IMASK_LO];
    end
  end

  // Divide and multiply flags carry no reset; their value after reset is undefined by design.
  always_ff @(posedge mclk) begin
    if (swUpd.we) begin
      mFlag_ff   <= swUpd.mFlag;
      qFlag_ff   <= swUpd.qFlag;
      satFlag_ff <= swUpd.satFlag;
    end else if (swWrite && (swAddr == CRF_STATUS_OFF)) begin
      mFlag_ff   <= swWrData[CRF_SW_MFLAG];
      qFlag_ff   <= swWrData[CRF_SW_QFLAG];
      satFlag_ff <= swWrData[CRF_SW_SAT];
    end
  end

  // ==========================================================
  // Operand and address paths
  // Effective address select; the vector mode scales the index held in the displacement by four.
  always_comb begin
    case (eaMode)
      CRF_EA_REG:     nxt_effAddr = gprFile_ff[rdSelA] + eaDisp;
      CRF_EA_INDEXED: nxt_effAddr = gprFile_ff[CRF_INDEX_GPR] + gprFile_ff[rdSelA];
      CRF_EA_PBASE:   nxt_effAddr = pbase_ff + eaDisp;
      CRF_EA_PCREL:   nxt_effAddr = pc_ff + eaDisp;
      CRF_EA_VECTOR:  nxt_effAddr = vbase_ff + {eaDisp[XLEN-3:0], 2'b00};
      default:        nxt_effAddr = CRF_ZERO;
    endcase
  end

  // Registered datapath outputs, one cycle after the select.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opA_ff      <= CRF_ZERO;
      opB_ff      <= CRF_ZERO;
      indexVal_ff <= CRF_ZERO;
      effAddr_ff  <= CRF_ZERO;
    end else begin
      opA_ff      <= gprFile_ff[rdSelA];
      opB_ff      <= gprFile_ff[rdSelB];
      indexVal_ff <= gprFile_ff[CRF_INDEX_GPR];
      effAddr_ff  <= nxt_effAddr;
    end
  end

  // ==========================================================
  // Software read port
  always_comb begin
    nxt_swRdData = CRF_ZERO;
    if (swRead) begin
      if (swGprHit) begin
        nxt_swRdData = gprFile_ff[swGprSel];
      end else begin
        case (swAddr)
          CRF_STATUS_OFF: nxt_swRdData = swView;
          CRF_PBASE_OFF:  nxt_swRdData = pbase_ff;
          CRF_VBASE_OFF:  nxt_swRdData = vbase_ff;
          CRF_PC_OFF:     nxt_swRdData = pc_ff;
          default:        nxt_swRdData = CRF_ZERO; // Unmapped reads return zero.
        endcase
      end
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      swRdData_ff <= CRF_ZERO;
    end else begin
      swRdData_ff <= nxt_swRdData;
    end
  end

  assign opA          = opA_ff;
  assign opB          = opB_ff;
  assign indexVal     = indexVal_ff;
  assign effAddr      = effAddr_ff;
  assign swRdData     = swRdData_ff;
  // Status and stack views come straight from their flops.
  assign statusWord   = swView;
  assign stackPointer = gprFile_ff[CRF_STACK_GPR];

endmodule

// [verif/crf_regfile_chk.sv]
// Assertion checker for the core register file, bound to every crf_regfile.
// Assumes one clock domain and a datapath that never writes r15 during a stack step.
`timescale 1ns/10ps
module crf_regfile_chk
  import crf_pkg::*;
#(
  parameter int XLEN = CRF_XLEN
) (
  // Clock and reset.
  input wire logic            mclk,
  input wire logic            rst,
  // Watched inputs.
  input wire logic            gprWe,
  input wire logic [3:0]      gprWrSel,
  input wire logic [XLEN-1:0] gprWrData,
  input wire logic [3:0]      rdSelA,
  input wire logic [3:0]      rdSelB,
  input wire logic            pbaseWe,
  input wire logic            vbaseWe,
  input wire logic            pcWe,
  input wire logic [XLEN-1:0] ctrlWrData,
  input wire logic [XLEN-1:0] pcWrData,
  input wire crf_swupd_t      swUpd,
  input wire crf_eamode_t     eaMode,
  input wire logic [XLEN-1:0] eaDisp,
  input wire crf_stkreq_t     stkReq,
  input wire logic [7:0]      swAddr,
  input wire logic            swRead,
  // Watched outputs.
  input wire logic [XLEN-1:0] opA,
  input wire logic [XLEN-1:0] opB,
  input wire logic [XLEN-1:0] indexVal,
  input wire logic [XLEN-1:0] effAddr,
  input wire logic [XLEN-1:0] statusWord,
  input wire logic [XLEN-1:0] stackPointer,
  input wire logic [XLEN-1:0] swRdData
);
  // ==========================================================
  // Sequences
  // Each one is a write followed by a request that must see it.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_gpr_hit;
    gprWe ##1 (rdSelA == $past(gprWrSel));
  endsequence
  sequence s_pbase_use;
    pbaseWe ##1 (eaMode == CRF_EA_PBASE);
  endsequence
  sequence s_vbase_use;
    vbaseWe ##1 (eaMode == CRF_EA_VECTOR);
  endsequence
  sequence s_pc_use;
    pcWe ##1 (eaMode == CRF_EA_PCREL);
  endsequence
  // ==========================================================
  // Properties
  chk_rsvd_read_zero: assert property (statusWord[31:10] == 22'h0 && statusWord[3:2] == 2'h0)
    else $error("status reserved bits not zero");
  chk_mask_reset_ones: assert property ($fell(rst) |-> statusWord[7:4] == 4'hf)
    else $error("interrupt mask not all ones after reset");
  chk_status_update: assert property (swUpd.we |=> statusWord[9:4] == {$past(swUpd.mFlag),
    $past(swUpd.qFlag), $past(swUpd.imask)} && statusWord[1] == $past(swUpd.satFlag))
    else $error("status word update lost");
  chk_status_readback: assert property (swRead && swAddr == CRF_STATUS_OFF |=> swRdData == $past(statusWord))
    else $error("status read differs from status view");
  chk_stack_step: assert property (|stkReq |=> stackPointer == ($past(stkReq.push) ?
    $past(stackPointer) - 32'h4 : $past(stackPointer) + 32'h4)) else $error("stack pointer step wrong");
  chk_gpr_write_read: assert property (s_gpr_hit |=> opA == $past(gprWrData, 2))
    else $error("general register write not seen");
  chk_opb_index_match: assert property (rdSelB == CRF_INDEX_GPR |=> opB == indexVal)
    else $error("second operand differs from index register");
  chk_reg_ea: assert property (eaMode == CRF_EA_REG |=> effAddr == opA + $past(eaDisp))
    else $error("register address wrong");
  chk_index_ea: assert property (eaMode == CRF_EA_INDEXED |=> effAddr == indexVal + opA)
    else $error("indexed address wrong");
  chk_pbase_ea: assert property (s_pbase_use |=> effAddr == $past(ctrlWrData, 2) + $past(eaDisp))
    else $error("peripheral base address wrong");
  chk_vector_ea: assert property (s_vbase_use |=> effAddr == $past(ctrlWrData, 2) + ($past(eaDisp) << 2))
    else $error("vector address wrong");
  chk_pcrel_ea: assert property (s_pc_use |=> effAddr == $past(pcWrData, 2) + $past(eaDisp))
    else $error("literal address wrong");
endmodule

bind crf_regfile crf_regfile_chk #(.XLEN(XLEN)) u_chk (
  .mclk, .rst, .gprWe, .gprWrSel, .gprWrData, .rdSelA, .rdSelB, .pbaseWe, .vbaseWe, .pcWe, .ctrlWrData,
  .pcWrData, .swUpd, .eaMode, .eaDisp, .stkReq, .swAddr, .swRead, .opA, .opB, .indexVal, .effAddr,
  .statusWord, .stackPointer, .swRdData
);

// [verif/crf_dp_model.sv]
// Behavioural execute datapath driving the register file's datapath inputs.
// Assumes the general registers are loaded before en rises.
`timescale 1ns/10ps
module crf_dp_model
  import crf_pkg::*;
(
  // Clock and enable.
  input  wire logic   mclk,
  input  wire logic   en,
  // Datapath requests.
  output logic        gprWe,
  output logic [3:0]  gprWrSel,
  output logic [31:0] gprWrData,
  output logic [3:0]  rdSelA,
  output logic [3:0]  rdSelB,
  output crf_eamode_t eaMode,
  output logic [31:0] eaDisp,
  output crf_stkreq_t stkReq,
  output crf_swupd_t  swUpd
);
  // ==========================================================
  // Random instruction stream
  // Idle keeps writes off and parks on a mode that needs a prior base write.
  task automatic drive(input logic act);
    gprWe     <= act & 1'($urandom);
    gprWrSel  <= 4'($urandom_range(14));
    gprWrData <= $urandom;
    rdSelA    <= 4'($urandom);
    rdSelB    <= 4'($urandom);
    eaMode    <= act ? crf_eamode_t'($urandom_range(4)) : CRF_EA_PBASE;
    eaDisp    <= $urandom;
    stkReq    <= act ? 2'($urandom) : 2'h0;
    swUpd     <= act ? 8'($urandom) : 8'h00;
  endtask
  // Never writing r15 keeps the stack pointer moved by push and pop alone.
  initial begin
    drive(1'b0);
    forever begin
      @(posedge mclk);
      drive(en);
    end
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the core register file.
// Assumes the bound checker judges the datapath side, which the datapath model only drives.
`timescale 1ns/10ps
module tb_top;
  import crf_pkg::*;
  logic        mclk, rst, en, gprWe, pbaseWe, vbaseWe, pcWe, swWrite, swRead, rdPend;
  logic [3:0]  gprWrSel, rdSelA, rdSelB;
  logic [7:0]  swAddr;
  logic [31:0] gprWrData, ctrlWrData, pcWrData, eaDisp, swWrData, swRdData, opA, opB, indexVal, effAddr;
  logic [31:0] statusWord, stackPointer, val [16];
  crf_swupd_t  swUpd;
  crf_eamode_t eaMode;
  crf_stkreq_t stkReq;
  logic [31:0] expQ [$];
  int          miscompares, compares, cycles;

  crf_regfile u_dut (.mclk, .rst, .rdSelA, .rdSelB, .gprWe, .gprWrSel, .gprWrData, .pbaseWe, .vbaseWe,
    .ctrlWrData, .swUpd, .pcWe, .pcWrData, .eaMode, .eaDisp, .stkReq, .opA, .opB, .indexVal, .effAddr,
    .statusWord, .stackPointer, .swAddr, .swWrData, .swWrite, .swRead, .swRdData);
  crf_dp_model u_dp (.mclk, .en, .gprWe, .gprWrSel, .gprWrData, .rdSelA, .rdSelB, .eaMode, .eaDisp,
    .stkReq, .swUpd);

  // ==========================================================
  // Software port tasks
  task automatic swWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {swAddr, swWrData, swWrite, swRead} <= {a, d, 2'b10};
  endtask
  task automatic swRd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    {swAddr, swWrite, swRead} <= {a, 2'b01};
    expQ.push_back(e);
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Read data is looked at only in the one cycle it stands.
  always @(posedge mclk) begin
    rdPend <= swRead;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
    if (rdPend === 1'b1) begin
      compares++;
      if (swRdData !== expQ[0]) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, swRdData, expQ[0]);
      end
      void'(expQ.pop_front());
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h4946));
    {rst, en, pbaseWe, vbaseWe, pcWe, swWrite, swRead, rdPend} = 8'h80;
    {ctrlWrData, pcWrData, swWrData, swAddr} = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    swRd(CRF_PBASE_OFF, 32'h0);
    swRd(CRF_VBASE_OFF, 32'h0);
    swRd(CRF_PC_OFF, 32'h0);
    swWr(CRF_STATUS_OFF, 32'h0000_03f2);
    swRd(CRF_STATUS_OFF, 32'h0000_03f2);
    swWr(CRF_STATUS_OFF, 32'h0);
    swRd(CRF_STATUS_OFF, 32'h0);
    swWr(8'h80, 32'h1234_5678);
    swRd(8'h80, 32'h0);
    swRd(8'h42, 32'h0);
    for (int i = 0; i < 19; i++) begin
      val[i % 16] = (i < 16) ? $urandom : val[i % 16];
      swWr((i < 16) ? 8'(4 * i) : 8'(CRF_PBASE_OFF + 4 * (i - 16)), $urandom);
    end
    for (int i = 0; i < 16; i++) swWr(8'(4 * i), val[i]);
    for (int i = 0; i < 16; i++) swRd(8'(4 * i), val[i]);
    swWr(CRF_VBASE_OFF, 32'hcafe_0000);
    swRd(CRF_VBASE_OFF, 32'hcafe_0000);
    @(posedge mclk);
    {swWrite, swRead, en} <= 3'b001;
    repeat (600) begin
      @(posedge mclk);
      {pbaseWe, vbaseWe, pcWe} <= 3'($urandom);
      ctrlWrData <= $urandom;
      pcWrData <= $urandom;
    end
    @(posedge mclk);
    {pbaseWe, vbaseWe, pcWe, en} <= 4'h0;
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule
